// [cwb_pkg.sv]
// cwb_pkg: constants, types and register map of the windowed channel register bank.
// assumes one 100 MHz clock and an Avalon-MM slave with 32-bit data, byte addresses.
package cwb_pkg;

   localparam int NCH  = 4;
   localparam int NREG = 17;

   // register indices; byte address is four times the index
   localparam logic [6:0] IDX_MODEM_CHANGE_OPTION_ONE = 7'h15;
   localparam logic [6:0] IDX_MODEM_CHANGE_OPTION_TWO = 7'h16;
   localparam logic [6:0] IDX_SCH1  = 7'h1A;
   localparam logic [6:0] IDX_SCH2  = 7'h1B;
   localparam logic [6:0] IDX_SCH3  = 7'h1C;
   localparam logic [6:0] IDX_SCH4  = 7'h1D;
   localparam logic [6:0] IDX_RECEIVE_TIMEOUT_PERIOD  = 7'h21;
   localparam logic [6:0] IDX_MATCH_RANGE_LOW  = 7'h22;
   localparam logic [6:0] IDX_MATCH_RANGE_HIGH  = 7'h23;
   localparam logic [6:0] IDX_LNC   = 7'h24;
   localparam logic [6:0] IDX_MSV1  = 7'h6C;
   localparam logic [6:0] IDX_MSV2  = 7'h6D;
   localparam logic [6:0] IDX_PRINTER_SIGNAL_VALUE  = 7'h6F;
   localparam logic [6:0] IDX_TRANSMIT_BIT_PERIOD  = 7'h72;
   localparam logic [6:0] IDX_TCLK  = 7'h76;
   localparam logic [6:0] IDX_RECEIVE_BIT_PERIOD  = 7'h78;
   localparam logic [6:0] IDX_RCLK  = 7'h7C;
   localparam logic [6:0] IDX_CSEL  = 7'h30;
   localparam logic [6:0] IDX_CTRL  = 7'h31;
   localparam logic [6:0] IDX_TXCH  = 7'h32;
   localparam logic [6:0] IDX_STAT  = 7'h33;
   localparam logic [6:0] IDX_RXCH  = 7'h34;

   // storage slot of each banked register, in the order listed above
   localparam logic [NREG-1:0][6:0] SLOT_IDX = {
      IDX_RCLK, IDX_RECEIVE_BIT_PERIOD, IDX_TCLK, IDX_TRANSMIT_BIT_PERIOD, IDX_PRINTER_SIGNAL_VALUE, IDX_MSV2, IDX_MSV1,
      IDX_LNC, IDX_MATCH_RANGE_HIGH, IDX_MATCH_RANGE_LOW, IDX_RECEIVE_TIMEOUT_PERIOD, IDX_SCH4, IDX_SCH3, IDX_SCH2,
      IDX_SCH1, IDX_MODEM_CHANGE_OPTION_TWO, IDX_MODEM_CHANGE_OPTION_ONE};
   localparam int SL_MODEM_CHANGE_OPTION_ONE = 0;
   localparam int SL_MODEM_CHANGE_OPTION_TWO = 1;
   localparam int SL_MSV1  = 10;
   localparam int SL_MSV2  = 11;
   localparam int SL_PRINTER_SIGNAL_VALUE  = 12;
   localparam int SL_TRANSMIT_BIT_PERIOD  = 13;
   localparam int SL_TCLK  = 14;
   localparam int SL_RECEIVE_BIT_PERIOD  = 15;
   localparam int SL_RCLK  = 16;

   // field positions
   localparam int MSV_STROBE_BIT = 3;
   localparam int PSV_ACK_BIT    = 3;
   localparam int MSV1_RTS_BIT   = 0;
   localparam int MSV2_DTR_BIT   = 1;
   localparam int CTRL_RXEN_BIT  = 0;
   localparam int CTRL_TXEN_BIT  = 1;
   localparam int CTRL_PAR_BIT   = 2;

   // values after reset and frame counts
   localparam logic [7:0] REG_RST    = 8'h00;
   localparam logic [3:0] TX_FRAME   = 4'hA;
   localparam logic [2:0] RX_LASTBIT = 3'h7;

   typedef enum logic {SQ_IDLE = 1'b0, SQ_SERVE = 1'b1} cwb_seq_e;

   typedef struct packed {
      logic [8:0]  address;
      logic        read;
      logic        write;
      logic [31:0] writedata;
      logic [3:0]  byteenable;
   } cwb_avs_req_s;

   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } cwb_avs_rsp_s;

   typedef struct packed {
      cwb_avs_rsp_s                     rsp;
      logic [1:0]                       csel;
      logic [1:0]                       idx;
      cwb_seq_e                         st;
      logic [7:0]                       psc;
      logic [NCH-1:0]                   rx_m;
      logic [NCH-1:0]                   rx_s;
      logic                             ack_m;
      logic                             ack_s;
      logic [NCH-1:0][2:0]              ctrl;
      logic [NCH-1:0][NREG-1:0][7:0]    regs;
      logic [NCH-1:0][7:0]              rxcnt;
      logic [NCH-1:0][7:0]              txcnt;
      logic [NCH-1:0]                   rxpend;
      logic [NCH-1:0]                   txpend;
      logic [NCH-1:0][7:0]              rxsh;
      logic [NCH-1:0][2:0]              rxbits;
      logic [NCH-1:0][7:0]              rxchar;
      logic [NCH-1:0]                   rxfull;
      logic [NCH-1:0]                   rxovr;
      logic [NCH-1:0][9:0]              txsh;
      logic [NCH-1:0][3:0]              txleft;
      logic [NCH-1:0]                   txline;
      logic [1:0]                       pphase;
      logic                             strobe_n;
      logic [7:0]                       pdata;
   } cwb_state_s;

endpackage : cwb_pkg

// [cwb_top.sv]
// cwb_top: windowed four-channel register bank with bit engines and sequencer.
// assumes an Avalon-MM master on mclk_i; rx_i and parallel_handshake_ack_n_i are asynchronous pins.
// assumes the host selects a channel first; a stopped engine drops its half-done work.
//
// The Avalon-MM interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none

module cwb_top (
   // clock and reset
   input  wire logic                  mclk_i,
   input  wire logic                  sys_rst_i,
   // register bus
   input  wire cwb_pkg::cwb_avs_req_s avs_req_i,
   output var  cwb_pkg::cwb_avs_rsp_s avs_rsp_o,
   // line pins
   input  wire logic [3:0]            rx_i,
   output logic      [3:0]            tx_o,
   output logic      [3:0]            rts_o,
   output logic      [3:0]            dtr_o,
   // parallel port on channel 0
   input  wire logic                  parallel_handshake_ack_n_i,
   output logic                       parallel_strobe_out_n_o,
   output logic      [7:0]            pdata_o
);
   import cwb_pkg::*;

   cwb_state_s s_q;
   cwb_state_s s_d;

   // storage slot of a register index, with hit flag
   function automatic logic [5:0] slot_of(input logic [6:0] idx);
      logic [5:0] r;
      r = 6'h00;
      for (int i = 0; i < NREG; i++) begin
         if (SLOT_IDX[i] == idx) begin
            r = {1'b1, 5'(i)};
         end
      end
      return r;
   endfunction : slot_of

   // bits that software may store, per layout
   function automatic logic [7:0] wmask(input logic [4:0] sl, input logic par);
      logic [7:0] m;
      m = 8'hFF;
      unique case (int'(sl))
         SL_MODEM_CHANGE_OPTION_ONE: m = par ? 8'hF0 : 8'hFF;
         SL_MODEM_CHANGE_OPTION_TWO: m = 8'hF0;
         SL_MSV1:  m = 8'hF1;
         SL_MSV2:  m = 8'hF2;
         SL_PRINTER_SIGNAL_VALUE:  m = 8'hF7;
         SL_TCLK:  m = 8'h07;
         SL_RCLK:  m = 8'h07;
         default:  m = 8'hFF;
      endcase
      return m;
   endfunction : wmask

   // signal-value slots whose bit 3 mirrors the strobe on channel 0
   function automatic logic is_sigval(input logic [4:0] sl);
      return (int'(sl) == SL_MSV1) || (int'(sl) == SL_MSV2);
   endfunction : is_sigval

   // enable pulse of the shared prescaler for a 3-bit clock select
   function automatic logic tick(input logic [7:0] psc, input logic [7:0] clksel);
      logic [7:0] m;
      m = 8'((9'h001 << clksel[2:0]) - 9'h001);
      return (psc & m) == m;
   endfunction : tick

   // pending channel next after the last served; a fast channel cannot starve the rest
   function automatic logic [1:0] pick(input logic [NCH-1:0] p, input logic [1:0] last);
      logic [1:0] r;
      logic [1:0] c;
      r = last;
      for (int i = NCH; i >= 1; i--) begin
         c = last + 2'(i);
         if (p[c]) begin
            r = c;
         end
      end
      return r;
   endfunction : pick

   logic [5:0]     hslot;
   logic [6:0]     hidx;
   logic           hpar;
   logic [7:0]     rd_val;
   logic [NCH-1:0] rx_en;
   logic [NCH-1:0] tx_en;

   // bit-engine enables; the parallel layout takes channel 0's receiver
   always_comb begin
      for (int c = 0; c < NCH; c++) begin
         rx_en[c] = s_q.ctrl[c][CTRL_RXEN_BIT] && !(c == 0 && s_q.ctrl[0][CTRL_PAR_BIT]);
         tx_en[c] = s_q.ctrl[c][CTRL_TXEN_BIT];
      end
   end

   always_comb begin
      hidx  = avs_req_i.address[8:2];
      hslot = slot_of(hidx);
      hpar  = (s_q.csel == 2'h0) && s_q.ctrl[0][CTRL_PAR_BIT];
      rd_val = 8'h00;
      if (hslot[5]) begin
         rd_val = s_q.regs[s_q.csel][hslot[4:0]] & wmask(hslot[4:0], hpar);
         if (is_sigval(hslot[4:0]) && s_q.csel == 2'h0) begin
            rd_val[MSV_STROBE_BIT] = s_q.strobe_n;
         end
         if (int'(hslot[4:0]) == SL_PRINTER_SIGNAL_VALUE && s_q.csel == 2'h0) begin
            rd_val[PSV_ACK_BIT] = s_q.ack_s;
         end
      end else begin
         unique case (hidx)
            IDX_CSEL: rd_val = {6'h00, s_q.csel};
            IDX_CTRL: rd_val = {5'h00, s_q.ctrl[s_q.csel]};
            IDX_STAT: rd_val = {5'h00, s_q.rxovr[s_q.csel], (s_q.txleft[s_q.csel] != 4'h0),
                                s_q.rxfull[s_q.csel]};
            IDX_RXCH: rd_val = s_q.rxchar[s_q.csel];
            default:  rd_val = 8'h00;
         endcase
      end
   end

   always_comb begin
      s_d = s_q;
      // pin synchronisers
      s_d.rx_m  = rx_i;
      s_d.rx_s  = s_q.rx_m;
      s_d.ack_m = parallel_handshake_ack_n_i;
      s_d.ack_s = s_q.ack_m;
      s_d.psc   = s_q.psc + 8'h01;

      // bus slave: one wait cycle, commit at the edge waitrequest is seen low
      // read data latched at the take edge, then held
      if (!s_q.rsp.waitrequest) begin
         s_d.rsp.waitrequest = 1'b1;
      end else if (avs_req_i.read || avs_req_i.write) begin
         s_d.rsp.waitrequest = 1'b0;
         s_d.rsp.readdata    = avs_req_i.read ? {24'h000000, rd_val} : 32'h00000000;
      end
      // reading the character frees it; a new one landing the same cycle wins
      if (!s_q.rsp.waitrequest && avs_req_i.read && hidx == IDX_RXCH) begin
         s_d.rxfull[s_q.csel] = 1'b0;
         s_d.rxovr[s_q.csel]  = 1'b0;
      end
      if (!s_q.rsp.waitrequest && avs_req_i.write && avs_req_i.byteenable[0]) begin
         if (hslot[5]) begin
            s_d.regs[s_q.csel][hslot[4:0]] = avs_req_i.writedata[7:0]
               & wmask(hslot[4:0], hpar);
         end else begin
            unique case (hidx)
               IDX_CSEL: s_d.csel = avs_req_i.writedata[1:0];
               IDX_CTRL: begin
                  s_d.ctrl[s_q.csel] = avs_req_i.writedata[2:0];
                  if (s_q.csel != 2'h0) begin
                     s_d.ctrl[s_q.csel][CTRL_PAR_BIT] = 1'b0;
                  end
               end
               IDX_TXCH: begin
                  if (s_q.txleft[s_q.csel] == 4'h0) begin
                     s_d.txsh[s_q.csel]   = {1'b1, avs_req_i.writedata[7:0], 1'b0};
                     s_d.txleft[s_q.csel] = TX_FRAME;
                  end
               end
               default: ;
            endcase
         end
      end

      // sequencer: load the index, then serve that channel only
      unique case (s_q.st)
         SQ_IDLE: begin
            if (|(s_q.rxpend | s_q.txpend)) begin
               s_d.idx = pick(s_q.rxpend | s_q.txpend, s_q.idx);
               s_d.st  = SQ_SERVE;
            end
         end
         SQ_SERVE: begin
            s_d.st = SQ_IDLE;
            if (s_q.rxpend[s_q.idx]) begin
               s_d.rxpend[s_q.idx] = 1'b0;
               s_d.rxsh[s_q.idx]   = {s_q.rx_s[s_q.idx], s_q.rxsh[s_q.idx][7:1]};
               s_d.rxbits[s_q.idx] = s_q.rxbits[s_q.idx] + 3'h1;
               if (s_q.rxbits[s_q.idx] == RX_LASTBIT) begin
                  s_d.rxchar[s_q.idx] = {s_q.rx_s[s_q.idx], s_q.rxsh[s_q.idx][7:1]};
                  s_d.rxovr[s_q.idx]  = s_q.rxfull[s_q.idx];
                  s_d.rxfull[s_q.idx] = 1'b1;
               end
            end
            if (s_q.txpend[s_q.idx]) begin
               s_d.txpend[s_q.idx] = 1'b0;
               if (s_q.idx == 2'h0 && s_q.ctrl[0][CTRL_PAR_BIT]) begin
                  // strobe low one bit time, high one bit time, then wait for ack
                  unique case (s_q.pphase)
                     2'h0: begin
                        if (s_q.txleft[0] != 4'h0) begin
                           s_d.pdata    = s_q.txsh[0][8:1];
                           s_d.strobe_n = 1'b0;
                           s_d.pphase   = 2'h1;
                        end
                     end
                     2'h1: begin
                        s_d.strobe_n = 1'b1;
                        s_d.pphase   = 2'h3;
                     end
                     2'h3: begin
                        if (!s_q.ack_s) begin
                           s_d.txleft[0] = 4'h0;
                           s_d.pphase    = 2'h0;
                        end
                     end
                     default: s_d.pphase = 2'h0;
                  endcase
               end else if (s_q.txleft[s_q.idx] != 4'h0) begin
                  s_d.txline[s_q.idx] = s_q.txsh[s_q.idx][0];
                  s_d.txsh[s_q.idx]   = {1'b1, s_q.txsh[s_q.idx][9:1]};
                  s_d.txleft[s_q.idx] = s_q.txleft[s_q.idx] - 4'h1;
               end
            end
         end
      endcase

      // bit engines: one period counter each way per channel; set wins over clear
      for (int c = 0; c < NCH; c++) begin
         // a stopped engine restarts its period and drops stale work
         if (!rx_en[c]) begin
            s_d.rxcnt[c]  = 8'h00;
            s_d.rxpend[c] = 1'b0;
            s_d.rxbits[c] = 3'h0;
         end
         if (!tx_en[c]) begin
            s_d.txcnt[c]  = 8'h00;
            s_d.txpend[c] = 1'b0;
            s_d.txleft[c] = 4'h0;
            s_d.txline[c] = 1'b1;
         end
         if (rx_en[c] && tick(s_q.psc, s_q.regs[c][SL_RCLK])) begin
            if (s_q.rxcnt[c] >= s_q.regs[c][SL_RECEIVE_BIT_PERIOD]) begin
               s_d.rxcnt[c]  = 8'h00;
               s_d.rxpend[c] = 1'b1;
            end else begin
               s_d.rxcnt[c] = s_q.rxcnt[c] + 8'h01;
            end
         end
         if (tx_en[c] && tick(s_q.psc, s_q.regs[c][SL_TCLK])) begin
            if (s_q.txcnt[c] >= s_q.regs[c][SL_TRANSMIT_BIT_PERIOD]) begin
               s_d.txcnt[c]  = 8'h00;
               s_d.txpend[c] = 1'b1;
            end else begin
               s_d.txcnt[c] = s_q.txcnt[c] + 8'h01;
            end
         end
      end

      // leaving parallel mode or stopping channel 0 mid-handshake frees the strobe
      if (!(s_q.ctrl[0][CTRL_PAR_BIT] && tx_en[0])) begin
         s_d.pphase   = 2'h0;
         s_d.strobe_n = 1'b1;
      end
   end

   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         s_q                 <= '0;
         s_q.regs            <= {(NCH * NREG){REG_RST}};
         s_q.rsp.waitrequest <= 1'b1;
         s_q.rx_m            <= 4'hF;
         s_q.rx_s            <= 4'hF;
         s_q.ack_m           <= 1'b1;
         s_q.ack_s           <= 1'b1;
         s_q.txline          <= 4'hF;
         s_q.strobe_n        <= 1'b1;
      end else begin
         s_q <= s_d;
      end
   end

   always_comb begin
      avs_rsp_o   = s_q.rsp;
      tx_o        = s_q.txline;
      parallel_strobe_out_n_o = s_q.strobe_n;
      pdata_o     = s_q.pdata;
      for (int c = 0; c < NCH; c++) begin
         rts_o[c] = s_q.regs[c][SL_MSV1][MSV1_RTS_BIT];
         dtr_o[c] = s_q.regs[c][SL_MSV2][MSV2_DTR_BIT];
      end
   end

endmodule : cwb_top
`default_nettype wire

// [cwb_top_sva.sv]
// cwb_top_sva: port-level checks of the register bus and parallel outputs.
// assumes binding into cwb_top; one clock, async active-high reset.
`timescale 1ns/1ps
`default_nettype none
module cwb_top_sva (
   // clock and reset
   input wire logic                  mclk_i,
   input wire logic                  sys_rst_i,
   // watched ports
   input wire cwb_pkg::cwb_avs_req_s avs_req_i,
   input wire cwb_pkg::cwb_avs_rsp_s avs_rsp_o,
   input wire logic [3:0]            rts_o,
   input wire logic [3:0]            dtr_o,
   input wire logic                  parallel_strobe_out_n_o,
   input wire logic [7:0]            pdata_o
);
   import cwb_pkg::*;
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (sys_rst_i);
   wait_one_a: assert property (!avs_rsp_o.waitrequest |=> avs_rsp_o.waitrequest)
      else $error("answer longer than one cycle");
   answer_next_a: assert property ((avs_req_i.read || avs_req_i.write) && avs_rsp_o.waitrequest
      |=> !avs_rsp_o.waitrequest) else $error("answer not one cycle after take");
   no_spurious_a: assert property (!avs_rsp_o.waitrequest
      |-> $past(avs_req_i.read || avs_req_i.write)) else $error("answer without request");
   upper_zero_a: assert property (!avs_rsp_o.waitrequest
      |-> avs_rsp_o.readdata[31:8] == 24'h0) else $error("upper read bits set");
   write_zero_a: assert property (!avs_rsp_o.waitrequest && avs_req_i.write
      |-> avs_rsp_o.readdata == 32'h0) else $error("read data on write answer");
   data_hold_a: assert property (avs_rsp_o.waitrequest && $past(avs_rsp_o.waitrequest)
      |-> $stable(avs_rsp_o.readdata)) else $error("read data moved while idle");
   pdata_hold_a: assert property (!parallel_strobe_out_n_o && $past(!parallel_strobe_out_n_o)
      |-> $stable(pdata_o)) else $error("parallel data moved under strobe");
   line_write_a: assert property ($changed(rts_o) || $changed(dtr_o)
      |-> $past(!avs_rsp_o.waitrequest) || $past(!avs_rsp_o.waitrequest, 2))
      else $error("line signal changed without write");
   cover property (!avs_rsp_o.waitrequest && avs_req_i.read);
   cover property (!avs_rsp_o.waitrequest && avs_req_i.write);
   cover property ($fell(parallel_strobe_out_n_o));
endmodule : cwb_top_sva
bind cwb_top cwb_top_sva u_sva (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .avs_req_i(avs_req_i),
   .avs_rsp_o(avs_rsp_o), .rts_o(rts_o), .dtr_o(dtr_o), .parallel_strobe_out_n_o(parallel_strobe_out_n_o),
   .pdata_o(pdata_o));
`default_nettype wire

// [cwb_far.sv]
// cwb_far: far-side model, serial loopback and a printer answering the strobe.
// assumes the bench clock and reset; lines idle high.
`timescale 1ns/1ps
`default_nettype none
module cwb_far (
   // clock and reset
   input  wire logic       mclk_i,
   input  wire logic       sys_rst_i,
   // lines
   input  wire logic [3:0] tx_i,
   input  wire logic       parallel_strobe_out_n_i,
   output logic      [3:0] rx_o,
   output logic            parallel_handshake_ack_n_o
);
   logic [3:0] cnt_q;
   logic       stb_q;
   assign rx_o = tx_i;
   // ack falls a few cycles after strobe rises, holds until next strobe
   always_ff @(posedge mclk_i or posedge sys_rst_i) begin
      if (sys_rst_i) begin
         cnt_q    <= 4'h0;
         stb_q    <= 1'b1;
         parallel_handshake_ack_n_o <= 1'b1;
      end else begin
         stb_q <= parallel_strobe_out_n_i;
         if (parallel_strobe_out_n_i && !stb_q) cnt_q <= 4'h3;
         else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
         if (!parallel_strobe_out_n_i) parallel_handshake_ack_n_o <= 1'b1;
         else if (cnt_q == 4'h1) parallel_handshake_ack_n_o <= 1'b0;
      end
   end
endmodule : cwb_far
`default_nettype wire

// [windowed_channel_register_bank_tb.sv]
// windowed_channel_register_bank_tb: self-checking bench for cwb_top.
// assumes cwb_far on the line side; reads are checked by a monitor queue.
`timescale 1ns/1ps
`default_nettype none
module windowed_channel_register_bank_tb;
   import cwb_pkg::*;
   logic         mclk_i = 1'b0;
   logic         sys_rst_i = 1'b1;
   cwb_avs_req_s req = '0;
   cwb_avs_rsp_s rsp;
   logic [3:0]   rx, tx, rts, dtr;
   logic         parallel_handshake_ack_n, pstb_n;
   logic [7:0]   pdata;
   logic [7:0]   expq[$];
   logic [7:0]   ex[4][10];
   logic [6:0]   fr[10] = '{IDX_SCH1, IDX_SCH2, IDX_SCH3, IDX_SCH4, IDX_RECEIVE_TIMEOUT_PERIOD,
                            IDX_MATCH_RANGE_LOW, IDX_MATCH_RANGE_HIGH, IDX_LNC, IDX_TRANSMIT_BIT_PERIOD, IDX_RECEIVE_BIT_PERIOD};
   logic [31:0]  rnd = 32'hF8D5;
   logic [9:0]   fb;
   int           failures = 0;
   int           total_checks = 0;
   cwb_top dut (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .avs_req_i(req), .avs_rsp_o(rsp),
      .rx_i(rx), .tx_o(tx), .rts_o(rts), .dtr_o(dtr), .parallel_handshake_ack_n_i(parallel_handshake_ack_n),
      .parallel_strobe_out_n_o(pstb_n), .pdata_o(pdata));
   cwb_far far (.mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .tx_i(tx), .parallel_strobe_out_n_i(pstb_n),
      .rx_o(rx), .parallel_handshake_ack_n_o(parallel_handshake_ack_n));
   initial begin
      forever #5 mclk_i = ~mclk_i;
   end
   function automatic logic [31:0] xs(input logic [31:0] x);
      x = x ^ (x << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   task automatic finish_test();
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("ALL TESTS PASSED");
      else $display("TESTS FAILED");
      $finish;
   endtask : finish_test
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      total_checks++;
      if (s !== e) begin
         failures++;
         $display("BAD %0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   task automatic bad();
      failures++;
      $display("BAD %0t wait ran out", $time);
      finish_test();
   endtask : bad
   // one bus access; reads note their expected byte
   task automatic acc(input logic r, input logic [6:0] ix, input logic [7:0] d,
                      input logic be, input logic [7:0] e);
      int n;
      n = 0;
      if (r) expq.push_back(e);
      req.address    <= {ix, 2'b00};
      req.read       <= r;
      req.write      <= !r;
      req.writedata  <= {24'h0, d};
      req.byteenable <= {3'h0, be};
      do begin
         @(posedge mclk_i);
         n++;
      end while (rsp.waitrequest !== 1'b0 && n < 50);
      if (n >= 50) bad();
      req.read  <= 1'b0;
      req.write <= 1'b0;
      @(posedge mclk_i);
   endtask : acc
   task automatic wr(input logic [6:0] ix, input logic [7:0] d);
      acc(1'b0, ix, d, 1'b1, 8'h00);
   endtask : wr
   task automatic rd(input logic [6:0] ix, input logic [7:0] e);
      acc(1'b1, ix, 8'h00, 1'b1, e);
   endtask : rd
   // sel 0 watches the line of channel 1, sel 1 the parallel strobe
   task automatic wait_low(input logic sel, input int lim);
      int n;
      n = 0;
      while ((sel ? pstb_n : tx[1]) !== 1'b0 && n < lim) begin
         @(posedge mclk_i);
         n++;
      end
      if (n >= lim) bad();
   endtask : wait_low
   always @(posedge mclk_i) begin
      if (rsp.waitrequest === 1'b0 && req.read === 1'b1) begin
         if (expq.size() == 0) chk(32'hFFFF_FFFF, 32'h0);
         else chk(rsp.readdata, {24'h0, expq.pop_front()});
      end
   end
   initial begin
      repeat (20) @(posedge mclk_i);
      sys_rst_i <= 1'b0;
      @(posedge mclk_i);
      rd(IDX_MODEM_CHANGE_OPTION_ONE, 8'h00);
      for (int c = 0; c < 4; c++) begin
         wr(IDX_CSEL, 8'(c));
         for (int i = 0; i < 10; i++) begin
            rnd = xs(rnd);
            ex[c][i] = rnd[7:0];
            wr(fr[i], ex[c][i]);
         end
      end
      for (int c = 0; c < 4; c++) begin
         wr(IDX_CSEL, 8'(c));
         for (int i = 0; i < 10; i++) rd(fr[i], ex[c][i]);
      end
      acc(1'b0, IDX_SCH1, 8'h5A, 1'b0, 8'h00);
      rd(IDX_SCH1, ex[3][0]);
      wr(7'h01, 8'hAA);
      rd(7'h01, 8'h00);
      wr(IDX_CSEL, 8'h00);
      wr(IDX_MSV1, 8'hFF);
      rd(IDX_MSV1, 8'hF9);
      chk(rts[0], 1'b1);
      wr(IDX_CSEL, 8'h01);
      wr(IDX_MSV1, 8'hFF);
      rd(IDX_MSV1, 8'hF1);
      wr(IDX_MSV2, 8'hFF);
      rd(IDX_MSV2, 8'hF2);
      chk(dtr[1], 1'b1);
      wr(IDX_MODEM_CHANGE_OPTION_TWO, 8'hFF);
      rd(IDX_MODEM_CHANGE_OPTION_TWO, 8'hF0);
      wr(IDX_TCLK, 8'hFF);
      rd(IDX_TCLK, 8'h07);
      wr(IDX_TCLK, 8'h00);
      wr(IDX_TRANSMIT_BIT_PERIOD, 8'h07);
      wr(IDX_CTRL, 8'h02);
      rnd = xs(rnd);
      fb = {1'b1, rnd[7:0], 1'b0};
      wr(IDX_TXCH, rnd[7:0]);
      wait_low(1'b0, 400);
      repeat (4) @(posedge mclk_i);
      for (int i = 0; i < 10; i++) begin
         chk(tx[1], fb[i]);
         repeat (8) @(posedge mclk_i);
      end
      wr(IDX_CSEL, 8'h02);
      wr(IDX_RECEIVE_BIT_PERIOD, 8'h01);
      wr(IDX_RCLK, 8'h00);
      wr(IDX_CTRL, 8'h01);
      repeat (100) @(posedge mclk_i);
      rd(IDX_RXCH, 8'hFF);
      wr(IDX_CSEL, 8'h00);
      wr(IDX_TRANSMIT_BIT_PERIOD, 8'h0F);
      wr(IDX_TCLK, 8'h00);
      wr(IDX_CTRL, 8'h06);
      wr(IDX_MODEM_CHANGE_OPTION_ONE, 8'hFF);
      rd(IDX_MODEM_CHANGE_OPTION_ONE, 8'hF0);
      rnd = xs(rnd);
      wr(IDX_TXCH, rnd[7:0]);
      wait_low(1'b1, 500);
      chk(pdata, rnd[7:0]);
      rd(IDX_MSV1, 8'hF1);
      repeat (200) @(posedge mclk_i);
      rd(IDX_STAT, 8'h00);
      repeat (3) @(posedge mclk_i);
      finish_test();
   end
endmodule : windowed_channel_register_bank_tb
`default_nettype wire
